//--- hdl/smiop_defs.svh
// Register indices, field positions and reset values of the seven-bit muxed port.
`ifndef SMIOP_DEFS_SVH
`define SMIOP_DEFS_SVH

// Register indices; the byte address on the bus is four times the index.
`define SMIOP_IDX_PORT_DIRECTION 16'hffbd
`define SMIOP_IDX_PORT_DATA_LATCH 16'hffbf
`define SMIOP_IDX_MUX_CONTROL 16'hffb0

// Reset values of the two port registers and of the mux control register.
`define SMIOP_RST_PORT_DIRECTION 8'h80
`define SMIOP_RST_PORT_DATA_LATCH 8'h80
`define SMIOP_RST_MUX_CONTROL 12'h000
// Inputs handed on at reset: host strobes and interrupt lines idle high, the rest low.
`define SMIOP_RST_PERIPH_IN 11'h07f

// Reserved bit of both port registers, and the value it reads as.
`define SMIOP_RSVD_BIT 7
`define SMIOP_DIRECTION_READ 8'hff

// Field positions inside the mux control register.
`define SMIOP_CTL_I2C_ENABLE 0
`define SMIOP_CTL_CLOCK_ENABLE_0 1
`define SMIOP_CTL_CLOCK_ENABLE_1 2
`define SMIOP_CTL_SYNC_MODE 3
`define SMIOP_CTL_RECEIVE_ENABLE 4
`define SMIOP_CTL_TRANSMIT_ENABLE 5
`define SMIOP_CTL_SLAVE_MODE 6
`define SMIOP_CTL_HOST_ACCESS_CONTROL 7
`define SMIOP_CTL_GATE_A20_ENABLE 8
`define SMIOP_CTL_IRQ_THREE_ENABLE 9
`define SMIOP_CTL_IRQ_FOUR_ENABLE 10
`define SMIOP_CTL_IRQ_FIVE_ENABLE 11

// Pin numbers of the port.
`define SMIOP_PIN_HOST_ADDR 0
`define SMIOP_PIN_GATE_A20 1
`define SMIOP_PIN_HOST_SEL_ONE 2
`define SMIOP_PIN_HOST_IO_READ 3
`define SMIOP_PIN_SERIAL_TX 4
`define SMIOP_PIN_SERIAL_RX 5
`define SMIOP_PIN_SERIAL_CLOCK 6

`endif

//--- hdl/smiop_pkg.sv
// Types shared by the seven-bit muxed port.
`default_nettype none
package smiop_pkg;

  // Mux control bits, one per field of the control register.
  typedef struct packed {
    logic irq_five_enable;
    logic irq_four_enable;
    logic irq_three_enable;
    logic gate_a20_enable;
    logic host_access_control;
    logic slave_mode;
    logic transmit_enable;
    logic receive_enable;
    logic sync_mode;
    logic clock_enable_1;
    logic clock_enable_0;
    logic i2c_enable;
  } smiop_ctl_t;

  // Drive of the seven pins.
  typedef struct packed {
    logic [6:0] oe;
    logic [6:0] out;
  } smiop_pins_t;

  // Inputs that the port hands on to the serial, I2C, host and interrupt logic.
  typedef struct packed {
    logic serial_clock_in;
    logic serial_receive_in;
    logic i2c_clock_in;
    logic host_addr_in;
    logic host_select_one;
    logic host_io_read;
    logic host_io_write;
    logic host_select_two;
    logic [2:0] irq_n;
  } smiop_periph_in_t;

  // Outputs of the on-chip functions that may own a pin.
  typedef struct packed {
    logic serial_clock_out;
    logic serial_transmit_out;
    logic i2c_clock_drive_low;
    logic gate_a20_out;
  } smiop_periph_out_t;

  // The whole state of the port.
  typedef struct packed {
    logic [6:0] direction;
    logic [6:0] data_latch;
    smiop_ctl_t ctl;
    smiop_pins_t pins;
    smiop_periph_in_t periph;
    logic waitrequest;
    logic [31:0] readdata;
  } smiop_state_t;

endpackage

`default_nettype wire

//--- hdl/smiop_port.sv
// Seven-bit general-purpose port with serial, I2C and host-interface pin sharing.
//
// Operation
// - Seven usable pins, six down to zero, each usable as general-purpose I/O.
// - A general-purpose pin drives when its direction bit is one, else is input.
// - Direction register is write-only; reading it returns all ones.
// - Bit seven of both registers ignores writes and reads as one.
// - Reset and hardware standby load direction register with 80 hex.
// - Software standby leaves direction unchanged; outputs keep driving.
// - Reset and hardware standby load data latch with 80 hex; software standby keeps it.
// - Reading data returns the latch for bits whose direction bit is one.
// - Reading data returns the live pin for bits whose direction bit is zero.
// - Those read rules hold even while a peripheral owns the pin.
// - Direction register shares its address with another port's input register.
// - Pin six: I2C clock, else serial clock in, else serial clock out, else GPIO.
// - Pin six feeds interrupt five whenever its enable is set.
// - Pin five: host select two, else serial receive, else GPIO.
// - Pin five feeds interrupt four, pin four feeds interrupt three, when enabled.
// - Pin four: host write, else serial transmit, else GPIO.
// - Slave mode makes pins three, two, zero host read, select one, address inputs.
// - Pin one, when its direction bit is one, drives gate-A20 in slave mode with its enable, else latch value.
`timescale 1ns/100ps
`default_nettype none
`include "smiop_defs.svh"

module smiop_port
  import smiop_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Hardware standby; initialises the registers like a reset while high.
  input wire logic hw_standby,
  // Avalon-MM slave.
  input wire logic [17:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Other port's input register that lives at the direction register's address.
  input wire logic [7:0] other_port_input_value,
  input wire logic other_port_claims_read,
  // Pins.
  input wire logic [6:0] pin_in,
  output logic [6:0] pin_out,
  output logic [6:0] pin_oe,
  // On-chip functions.
  input wire smiop_periph_out_t periph_out,
  output smiop_periph_in_t periph_in,
  output smiop_ctl_t mux_control
);

  smiop_state_t s_q;
  smiop_state_t s_d;

  // Decoded bus request and helper terms.
  logic req;
  logic take;
  logic hit_dir;
  logic hit_data;
  logic hit_ctl;
  logic host_owns_rx_tx;
  logic [7:0] data_read;
  smiop_pins_t own;

  assign req = avs_read | avs_write;
  // The request completes at the edge where waitrequest is seen low.
  assign take = req & ~s_q.waitrequest;
  assign hit_dir = (avs_address[17:2] == `SMIOP_IDX_PORT_DIRECTION) &&
                   (avs_address[1:0] == 2'h0);
  assign hit_data = (avs_address[17:2] == `SMIOP_IDX_PORT_DATA_LATCH) &&
                    (avs_address[1:0] == 2'h0);
  assign hit_ctl = (avs_address[17:2] == `SMIOP_IDX_MUX_CONTROL) &&
                   (avs_address[1:0] == 2'h0);
  assign host_owns_rx_tx = s_q.ctl.slave_mode & ~s_q.ctl.host_access_control;

  // Data read: latch where the direction bit is one, pin level where zero.
  // Ownership by a peripheral does not change this view.
  assign data_read = {1'b1,
                      (s_q.direction & s_q.data_latch) |
                      (~s_q.direction & pin_in)};

  // Pin ownership and drive; earlier branches take priority.
  always_comb begin
    own.oe = s_q.direction;
    own.out = s_q.data_latch;
    // Pin six.
    if (s_q.ctl.i2c_enable) begin
      // Open-drain clock: only ever pulled low.
      own.oe[`SMIOP_PIN_SERIAL_CLOCK] = periph_out.i2c_clock_drive_low;
      own.out[`SMIOP_PIN_SERIAL_CLOCK] = 1'b0;
    end else if (s_q.ctl.clock_enable_1) begin
      own.oe[`SMIOP_PIN_SERIAL_CLOCK] = 1'b0;
      own.out[`SMIOP_PIN_SERIAL_CLOCK] = 1'b0;
    end else if (s_q.ctl.sync_mode | s_q.ctl.clock_enable_0) begin
      own.oe[`SMIOP_PIN_SERIAL_CLOCK] = 1'b1;
      own.out[`SMIOP_PIN_SERIAL_CLOCK] = periph_out.serial_clock_out;
    end
    // Pin five.
    if (host_owns_rx_tx || s_q.ctl.receive_enable) begin
      own.oe[`SMIOP_PIN_SERIAL_RX] = 1'b0;
      own.out[`SMIOP_PIN_SERIAL_RX] = 1'b0;
    end
    // Pin four.
    if (host_owns_rx_tx) begin
      own.oe[`SMIOP_PIN_SERIAL_TX] = 1'b0;
      own.out[`SMIOP_PIN_SERIAL_TX] = 1'b0;
    end else if (s_q.ctl.transmit_enable) begin
      own.oe[`SMIOP_PIN_SERIAL_TX] = 1'b1;
      own.out[`SMIOP_PIN_SERIAL_TX] = periph_out.serial_transmit_out;
    end
    // Pins three, two and zero are host inputs in slave mode.
    if (s_q.ctl.slave_mode) begin
      own.oe[`SMIOP_PIN_HOST_IO_READ] = 1'b0;
      own.oe[`SMIOP_PIN_HOST_SEL_ONE] = 1'b0;
      own.oe[`SMIOP_PIN_HOST_ADDR] = 1'b0;
      own.out[`SMIOP_PIN_HOST_IO_READ] = 1'b0;
      own.out[`SMIOP_PIN_HOST_SEL_ONE] = 1'b0;
      own.out[`SMIOP_PIN_HOST_ADDR] = 1'b0;
    end
    // Pin one keeps its direction bit; only the driven value changes.
    if (s_q.direction[`SMIOP_PIN_GATE_A20] && s_q.ctl.slave_mode &&
        s_q.ctl.gate_a20_enable) begin
      own.out[`SMIOP_PIN_GATE_A20] = periph_out.gate_a20_out;
    end
  end

  // Next state: registers, bus answer, pin drive and inputs passed on.
  always_comb begin
    s_d = s_q;
    // Answer every request with exactly one wait cycle.
    s_d.waitrequest = 1'b1;
    if (req && s_q.waitrequest) begin
      s_d.waitrequest = 1'b0;
      s_d.readdata = 32'h0000_0000;
      if (avs_read) begin
        if (hit_dir) begin
          s_d.readdata[7:0] = other_port_claims_read ? other_port_input_value
                                                     : `SMIOP_DIRECTION_READ;
        end else if (hit_data) begin
          s_d.readdata[7:0] = data_read;
        end else if (hit_ctl) begin
          s_d.readdata[11:0] = s_q.ctl;
        end
      end
    end
    // Writes land at the completing edge; bit seven is never stored.
    if (take && avs_write && avs_byteenable[0]) begin
      if (hit_dir) begin
        s_d.direction = avs_writedata[6:0];
      end else if (hit_data) begin
        s_d.data_latch = avs_writedata[6:0];
      end else if (hit_ctl && avs_byteenable[1]) begin
        s_d.ctl = smiop_ctl_t'(avs_writedata[11:0]);
      end
    end
    // Hardware standby reloads like reset; no software standby path exists, so it
    // keeps everything, including output drive.
    if (hw_standby) begin
      // Bit seven is reserved and never stored, so only the low seven bits load.
      s_d.direction = 7'(`SMIOP_RST_PORT_DIRECTION);
      s_d.data_latch = 7'(`SMIOP_RST_PORT_DATA_LATCH);
      s_d.ctl = smiop_ctl_t'(`SMIOP_RST_MUX_CONTROL);
    end
    s_d.pins = own;
    // Inputs to the functions; host strobes idle high while not owned.
    s_d.periph.serial_clock_in = pin_in[`SMIOP_PIN_SERIAL_CLOCK];
    s_d.periph.i2c_clock_in = pin_in[`SMIOP_PIN_SERIAL_CLOCK];
    s_d.periph.serial_receive_in = pin_in[`SMIOP_PIN_SERIAL_RX];
    s_d.periph.host_select_two = host_owns_rx_tx ? pin_in[`SMIOP_PIN_SERIAL_RX] : 1'b1;
    s_d.periph.host_io_write = host_owns_rx_tx ? pin_in[`SMIOP_PIN_SERIAL_TX] : 1'b1;
    s_d.periph.host_io_read = s_q.ctl.slave_mode ? pin_in[`SMIOP_PIN_HOST_IO_READ] : 1'b1;
    s_d.periph.host_select_one = s_q.ctl.slave_mode ? pin_in[`SMIOP_PIN_HOST_SEL_ONE]
                                                    : 1'b1;
    s_d.periph.host_addr_in = s_q.ctl.slave_mode ? pin_in[`SMIOP_PIN_HOST_ADDR] : 1'b0;
    // Interrupt lines follow the pins regardless of owner, idle high when disabled.
    s_d.periph.irq_n[2] = s_q.ctl.irq_five_enable ?
                          pin_in[`SMIOP_PIN_SERIAL_CLOCK] : 1'b1;
    s_d.periph.irq_n[1] = s_q.ctl.irq_four_enable ?
                          pin_in[`SMIOP_PIN_SERIAL_RX] : 1'b1;
    s_d.periph.irq_n[0] = s_q.ctl.irq_three_enable ?
                          pin_in[`SMIOP_PIN_SERIAL_TX] : 1'b1;
  end

  // State register; reset puts every pin to input and the bus in wait.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q.direction <= 7'(`SMIOP_RST_PORT_DIRECTION);
      s_q.data_latch <= 7'(`SMIOP_RST_PORT_DATA_LATCH);
      s_q.ctl <= smiop_ctl_t'(`SMIOP_RST_MUX_CONTROL);
      s_q.pins <= '0;
      s_q.periph <= smiop_periph_in_t'(`SMIOP_RST_PERIPH_IN);
      s_q.waitrequest <= 1'b1;
      s_q.readdata <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register.
  assign avs_readdata = s_q.readdata;
  assign avs_waitrequest = s_q.waitrequest;
  assign pin_out = s_q.pins.out;
  assign pin_oe = s_q.pins.oe;
  assign periph_in = s_q.periph;
  assign mux_control = s_q.ctl;

endmodule

`default_nettype wire

//--- sim/smiop_pins_mdl.sv
// Far side of the port: pin wiring and the on-chip functions.
`timescale 1ns/100ps
`default_nettype none
module smiop_pins_mdl
  import smiop_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Port drive and the outside level.
  input wire logic [6:0] pin_out,
  input wire logic [6:0] pin_oe,
  input wire logic [6:0] ext_level,
  // Levels seen by the port.
  output logic [6:0] pin_in,
  output var smiop_periph_out_t periph_out
);
  logic [2:0] cnt_q = 3'h0;
  // A driven pin shows the port's value; a released pin shows the outside level.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
  // Function outputs follow a free-running counter, so a stale sample shows up; gate-A20 stays high.
  always @(posedge clk) cnt_q <= cnt_q + 3'h1;
  assign periph_out = {cnt_q, 1'b1};
endmodule
`default_nettype wire

//--- sim/smiop_port_chk.sv
// Concurrent checks on the ports of the seven-bit muxed port.
`timescale 1ns/100ps
`default_nettype none
module smiop_port_chk
  import smiop_pkg::*;
(
  // Clock, reset and bus.
  input wire logic clk,
  input wire logic rstn,
  input wire logic [17:0] avs_address,
  input wire logic avs_read,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Shared address, pins and functions.
  input wire logic [7:0] other_port_input_value,
  input wire logic other_port_claims_read,
  input wire logic [6:0] pin_in,
  input wire logic [6:0] pin_out,
  input wire logic [6:0] pin_oe,
  input wire smiop_periph_out_t periph_out,
  input wire smiop_periph_in_t periph_in,
  input wire smiop_ctl_t mux_control
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic rd_done;
  logic host_mode;
  // Read completion, and host strobes owning pins five and four.
  assign rd_done = avs_read && !avs_waitrequest;
  assign host_mode = mux_control.slave_mode && !mux_control.host_access_control;
  chk_dir_ones: assert property (
    rd_done && avs_address == 18'h3fef4 && !other_port_claims_read |-> avs_readdata == 32'hff)
    else $error("direction read not all ones");
  chk_shared_addr: assert property (
    rd_done && avs_address == 18'h3fef4 && other_port_claims_read
    |-> avs_readdata == {24'h0, other_port_input_value}) else $error("shared read wrong");
  chk_data_rsvd: assert property (
    rd_done && avs_address == 18'h3fefc |-> avs_readdata[31:7] == 25'h1)
    else $error("data read upper bits wrong");
  chk_host_inputs: assert property (
    mux_control.slave_mode |=> pin_oe[3:2] == 2'h0 && !pin_oe[0] &&
    periph_in.host_io_read == $past(pin_in[3]) && periph_in.host_select_one == $past(pin_in[2])
    && periph_in.host_addr_in == $past(pin_in[0])) else $error("host pin driven");
  chk_host_strobes: assert property (
    host_mode |=> pin_oe[5:4] == 2'h0 && periph_in.host_select_two == $past(pin_in[5]) &&
    periph_in.host_io_write == $past(pin_in[4])) else $error("host strobe pin driven");
  chk_sck_out: assert property (
    (mux_control.sync_mode || mux_control.clock_enable_0) && !mux_control.clock_enable_1 &&
    !mux_control.i2c_enable |=> pin_oe[6] && pin_out[6] == $past(periph_out.serial_clock_out))
    else $error("serial clock output wrong");
  chk_sck_in: assert property (
    mux_control.clock_enable_1 && !mux_control.i2c_enable
    |=> !pin_oe[6] && periph_in.serial_clock_in == $past(pin_in[6]))
    else $error("serial clock input wrong");
  chk_rx_in: assert property (
    mux_control.receive_enable |=> periph_in.serial_receive_in == $past(pin_in[5]))
    else $error("serial receive input wrong");
  chk_tx_drive: assert property (
    !host_mode && mux_control.transmit_enable
    |=> pin_oe[4] && pin_out[4] == $past(periph_out.serial_transmit_out))
    else $error("transmit pin not driven by serial");
  chk_scl_drain: assert property (
    mux_control.i2c_enable |=> pin_oe[6] == $past(periph_out.i2c_clock_drive_low) && !pin_out[6]
    && periph_in.i2c_clock_in == $past(pin_in[6])) else $error("i2c clock drive wrong");
  chk_irq_five: assert property (
    mux_control.irq_five_enable |=> periph_in.irq_n[2] == $past(pin_in[6]))
    else $error("irq five not following pin six");
  chk_irq_four: assert property (
    mux_control.irq_four_enable |=> periph_in.irq_n[1] == $past(pin_in[5]))
    else $error("irq four not following pin five");
  chk_irq_three: assert property (
    mux_control.irq_three_enable |=> periph_in.irq_n[0] == $past(pin_in[4]))
    else $error("irq three not following pin four");
  cov_data_read: cover property (rd_done && avs_address == 18'h3fefc);
  cov_host_mode: cover property (host_mode);
  cov_i2c_low: cover property (mux_control.i2c_enable && pin_oe[6]);
endmodule
bind smiop_port smiop_port_chk u_chk (.clk, .rstn, .avs_address, .avs_read, .avs_readdata,
  .avs_waitrequest, .other_port_input_value, .other_port_claims_read, .pin_in, .pin_out,
  .pin_oe, .periph_out, .periph_in, .mux_control);
`default_nettype wire

//--- sim/smiop_port_tb.sv
// Self-checking bench of the seven-bit muxed port.
`timescale 1ns/100ps
`default_nettype none
module smiop_port_tb;
  import smiop_pkg::*;
  localparam logic [17:0] DIR = 18'h3fef4;
  localparam logic [17:0] DAT = 18'h3fefc;
  localparam logic [17:0] CTL = 18'h3fec0;
  logic clk = 0, rstn = 0, hw_standby = 0, avs_read = 0, avs_write = 0;
  logic other_port_claims_read = 0, avs_waitrequest;
  logic [17:0] avs_address = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = '0, avs_readdata, q;
  logic [7:0] other_port_input_value = 8'h5c;
  logic [6:0] pin_in, pin_out, pin_oe, ext_level = 7'h55;
  smiop_periph_out_t periph_out;
  smiop_periph_in_t periph_in;
  smiop_ctl_t mux_control;
  int err_total = 0, total_checks = 0;
  // Free-running 100 MHz clock.
  always #5 clk = ~clk;
  smiop_port DUT (.clk, .rstn, .hw_standby, .avs_address, .avs_read, .avs_write,
    .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .other_port_input_value, .other_port_claims_read, .pin_in, .pin_out, .pin_oe,
    .periph_out, .periph_in, .mux_control);
  smiop_pins_mdl u_far (.clk, .pin_out, .pin_oe, .ext_level, .pin_in, .periph_out);
  // One bus cycle; the request stands until waitrequest is seen low.
  // Only the watchdog ends a wait that never completes.
  task automatic xfer(input bit w, input logic [17:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Pin outputs land one edge after a write completes; the check samples at the second edge.
  task automatic oe_is(input string nm, input logic [6:0] e);
    repeat (2) @(posedge clk);
    cmp(nm, {25'h0, e}, {25'h0, pin_oe});
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // A hang counts as a mismatch; the tests need about a hundred cycles.
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_sim();
  end
  // Main sequence.
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    xfer(0, DIR, 0);
    cmp("dir", 32'hff, q);
    xfer(0, DAT, 0);
    cmp("dat_rst", 32'hd5, q);
    xfer(1, DIR, 32'h0f);
    xfer(1, DAT, 32'h3a);
    oe_is("oe", 7'h0f);
    cmp("out", 32'ha, {25'h0, pin_out & pin_oe});
    xfer(0, DAT, 0);
    cmp("dat_mix", 32'hda, q);
    avs_byteenable <= 4'h0;
    xfer(1, DIR, 32'h7f);
    avs_byteenable <= 4'hf;
    oe_is("be0", 7'h0f);
    xfer(1, DIR, 32'h7f);
    xfer(1, DAT, 32'h48);
    xfer(1, CTL, 32'he01);
    xfer(0, CTL, 0);
    cmp("ctl", 32'he01, q);
    xfer(0, DAT, 0);
    cmp("dat_i2c", 32'hc8, q);
    xfer(1, CTL, 32'h040);
    oe_is("slave", 7'h42);
    xfer(1, CTL, 32'h140);
    oe_is("gate_a20_out_oe", 7'h42);
    cmp("gate_a20_out", 32'h2, {25'h0, pin_out & 7'h02});
    // Pins four down to zero now stand opposite to the latch, so only the latch reads back.
    xfer(0, DAT, 0);
    cmp("dat_gate_a20_out", 32'hc8, q);
    xfer(1, CTL, 32'h0e0);
    oe_is("hac", 7'h72);
    xfer(1, CTL, 32'h006);
    oe_is("ce1", 7'h3f);
    xfer(1, CTL, 32'h018);
    oe_is("sync_rx", 7'h5f);
    hw_standby <= 1'b1;
    repeat (2) @(posedge clk);
    hw_standby <= 1'b0;
    oe_is("stby", 7'h00);
    xfer(0, CTL, 0);
    cmp("ctl_stby", 32'h0, q);
    xfer(1, DIR, 32'h7f);
    xfer(0, DAT, 0);
    cmp("dat_stby", 32'h80, q);
    other_port_claims_read <= 1'b1;
    xfer(0, DIR, 0);
    cmp("shared", 32'h5c, q);
    other_port_claims_read <= 1'b0;
    xfer(0, 18'h3fef8, 0);
    cmp("unmapped", 32'h0, q);
    end_sim();
  end
endmodule
`default_nettype wire
